// [verilog/lft_top.sv]
// Purpose: Lane buffer fault flags and sampling trim registers on AXI4-Lite
// Assumes: Lane fault and mode inputs are synchronous to CLK_SYS
// Notes:   One write and one read may be outstanding; answers are fixed latency
// Functional notes
// - Bit i of the 16-bit lane fault register sets whenever lane i's buffer overflows or underflows.
// - Writing a one to a lane fault bit clears it, zero bits leave their flags alone.
// - A fault that persists sets its flag again straight after a clear.
// - Writing a one to the buffer fault summary bit clears all sixteen lane flags.
// - After reset every lane fault flag reads as one.
// - Each trim register is an 8-bit read/write field setting a core's sampling instant.
// - Trim registers load factory values that software can read back and overwrite.
// - The dual core A trim sets core A's sampling instant in two-channel mode.
// - The dual core B trim sets core B's sampling instant in two-channel mode with calibration on.
// - In single-channel mode with calibration, core A uses the in-A or in-B trim, core B likewise its in-A or in-B trim.
// - The summary bit sets whenever any active lane buffer overflows or underflows.
// - In single-channel mode with calibration, core B sampling input B uses its own trim.
//
// Our own choice: register access over AXI4-Lite.
module lft_top (
  input  wire logic                         CLK_SYS,
  input  wire logic                         RST,
  input  wire logic [lft_pkg::ADDR_W-1:0]   S_AXI_AWADDR,
  input  wire logic                         S_AXI_AWVALID,
  output      logic                         S_AXI_AWREADY,
  input  wire logic [31:0]                  S_AXI_WDATA,
  input  wire logic [3:0]                   S_AXI_WSTRB,
  input  wire logic                         S_AXI_WVALID,
  output      logic                         S_AXI_WREADY,
  output      logic [1:0]                   S_AXI_BRESP,
  output      logic                         S_AXI_BVALID,
  input  wire logic                         S_AXI_BREADY,
  input  wire logic [lft_pkg::ADDR_W-1:0]   S_AXI_ARADDR,
  input  wire logic                         S_AXI_ARVALID,
  output      logic                         S_AXI_ARREADY,
  output      logic [31:0]                  S_AXI_RDATA,
  output      logic [1:0]                   S_AXI_RRESP,
  output      logic                         S_AXI_RVALID,
  input  wire logic                         S_AXI_RREADY,
  input  wire logic [lft_pkg::LANES-1:0]    LANE_FAULT,
  input  wire logic [lft_pkg::LANES-1:0]    LANE_ACTIVE,
  input  wire lft_pkg::lft_mode_s           MODE,
  input  wire logic                         FUSE_LOAD,
  input  wire logic [lft_pkg::TRIMS*8-1:0]  FUSE_TRIM,
  output      lft_pkg::lft_pair_s           APPLIED,
  output      logic                         IRQ
);

  // Index match on a word-aligned byte address
  function automatic logic hit(input logic [lft_pkg::ADDR_W-1:0] a, input logic [9:0] idx);
    hit = (a[lft_pkg::ADDR_W-1:2] == idx);
  endfunction

  logic                        aw_full_q;
  logic [lft_pkg::ADDR_W-1:0]  awaddr_q;
  logic                        w_full_q;
  logic [31:0]                 wdata_q;
  logic [3:0]                  wstrb_q;
  logic                        bvalid_q;
  logic [1:0]                  bresp_q;
  logic                        rvalid_q;
  logic [31:0]                 rdata_q;
  logic [1:0]                  rresp_q;
  logic [15:0]                 flags_q;
  logic [15:0]                 flags_d;
  logic                        sum_q;
  logic                        sum_d;
  logic [lft_pkg::IRQ_W-1:0]   irq_sts_q;
  logic [lft_pkg::IRQ_W-1:0]   irq_sts_d;
  logic [lft_pkg::IRQ_W-1:0]   irq_en_q;
  lft_pkg::lft_trim_t          trim_q [lft_pkg::TRIMS];
  lft_pkg::lft_pair_s          applied_q;
  lft_pkg::lft_pair_s          applied_d;

  // Write side decode, done once both address and data are held
  wire        do_wr     = aw_full_q & w_full_q & ~bvalid_q;
  wire        wr_fault  = do_wr & hit(awaddr_q, lft_pkg::IDX_FAULT);
  wire        wr_alarm  = do_wr & hit(awaddr_q, lft_pkg::IDX_ALARM);
  wire        wr_irqclr = do_wr & hit(awaddr_q, lft_pkg::IDX_IRQ_CLR);
  wire        wr_irqen  = do_wr & hit(awaddr_q, lft_pkg::IDX_IRQ_EN);
  wire [15:0] lane_mask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [15:0] lane_clr  = wr_fault ? (wdata_q[15:0] & lane_mask) : 16'h0000;
  wire        sum_clr   = wr_alarm & wstrb_q[0] & wdata_q[lft_pkg::SUM_BIT];
  wire        any_act   = |(LANE_FAULT & LANE_ACTIVE);
  wire        new_fault = |(LANE_FAULT & ~flags_q);
  logic [lft_pkg::TRIMS-1:0] wr_trim;

  // Fault always ORs in after the clear, so a live fault is never lost
  assign flags_d   = sum_clr ? LANE_FAULT : ((flags_q & ~lane_clr) | LANE_FAULT);
  assign sum_d     = (sum_q & ~sum_clr) | any_act;
  assign irq_sts_d = (irq_sts_q & ~((wr_irqclr & wstrb_q[0]) ? wdata_q[lft_pkg::IRQ_W-1:0] : '0))
                     | lft_pkg::IRQ_W'(new_fault);

  // Handshake outputs
  assign S_AXI_AWREADY = ~aw_full_q;
  assign S_AXI_WREADY  = ~w_full_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = ~rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;
  assign APPLIED       = applied_q;
  assign IRQ           = |(irq_sts_q & irq_en_q);

  // Write channel capture, each channel taken independently, both released together on do_wr
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      aw_full_q <= 1'b0;
      awaddr_q  <= '0;
      w_full_q  <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && !aw_full_q) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= S_AXI_AWADDR;
      end else if (do_wr) begin
        aw_full_q <= 1'b0;
      end
      if (S_AXI_WVALID && !w_full_q) begin
        w_full_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA;
        wstrb_q  <= S_AXI_WSTRB;
      end else if (do_wr) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR and change nothing
  wire wr_mapped = wr_fault | wr_alarm | wr_irqclr | wr_irqen | (|wr_trim)
                   | hit(awaddr_q, lft_pkg::IDX_IRQ_STS);
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      bvalid_q <= 1'b0;
      bresp_q  <= lft_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_mapped ? lft_pkg::RESP_OKAY : lft_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  // Fault flags, summary and interrupt state
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      flags_q   <= lft_pkg::FAULT_RST;
      sum_q     <= lft_pkg::SUM_RST;
      irq_sts_q <= '0;
      irq_en_q  <= '0;
    end else begin
      flags_q   <= flags_d;
      sum_q     <= sum_d;
      irq_sts_q <= irq_sts_d;
      if (wr_irqen && wstrb_q[0]) begin
        irq_en_q <= wdata_q[lft_pkg::IRQ_W-1:0];
      end
    end
  end

  // Trim registers; a fuse load outranks a software write in the same cycle
  for (genvar k = 0; k < lft_pkg::TRIMS; k++) begin : g_trim
    assign wr_trim[k] = do_wr & hit(awaddr_q, lft_pkg::IDX_TRIM[k]);
    always_ff @(posedge CLK_SYS) begin
      if (RST) begin
        trim_q[k] <= lft_pkg::TRIM_RST;
      end else if (FUSE_LOAD) begin
        trim_q[k] <= FUSE_TRIM[k*8 +: 8];
      end else if (wr_trim[k] && wstrb_q[0]) begin
        trim_q[k] <= wdata_q[7:0];
      end
    end
    AST_TRIM_WR: assert property (@(posedge CLK_SYS) disable iff (RST)
      (wr_trim[k] && wstrb_q[0] && !FUSE_LOAD) |=> trim_q[k] == $past(wdata_q[7:0]))
      else $error("Trim write not stored");
    AST_FUSE: assert property (@(posedge CLK_SYS) disable iff (RST)
      FUSE_LOAD |=> trim_q[k] == $past(FUSE_TRIM[k*8 +: 8]))
      else $error("Fuse value not loaded");
  end

  // Trim in force per core; single-channel picks by sampled input
  assign applied_d.core_a = MODE.dual ? trim_q[lft_pkg::T_A_DUAL]
                          : (MODE.in_b ? trim_q[lft_pkg::T_A_IN_B] : trim_q[lft_pkg::T_A_IN_A]);
  assign applied_d.core_b = MODE.dual ? trim_q[lft_pkg::T_B_DUAL]
                          : (MODE.in_b ? trim_q[lft_pkg::T_B_IN_B] : trim_q[lft_pkg::T_B_IN_A]);

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      applied_q <= '0;
    end else begin
      applied_q <= applied_d;
    end
  end

  // Read data select
  wire [lft_pkg::ADDR_W-1:0] ra = S_AXI_ARADDR;
  logic [31:0] rd_val;
  logic        rd_hit;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b0;
    if (hit(ra, lft_pkg::IDX_FAULT)) begin
      rd_val = {16'h0000, flags_q};
      rd_hit = 1'b1;
    end
    if (hit(ra, lft_pkg::IDX_ALARM)) begin
      rd_val[lft_pkg::SUM_BIT] = sum_q;
      rd_hit = 1'b1;
    end
    if (hit(ra, lft_pkg::IDX_IRQ_STS)) begin
      rd_val[lft_pkg::IRQ_W-1:0] = irq_sts_q;
      rd_hit = 1'b1;
    end
    if (hit(ra, lft_pkg::IDX_IRQ_EN)) begin
      rd_val[lft_pkg::IRQ_W-1:0] = irq_en_q;
      rd_hit = 1'b1;
    end
    if (hit(ra, lft_pkg::IDX_IRQ_CLR)) begin
      rd_hit = 1'b1;
    end
    for (int i = 0; i < lft_pkg::TRIMS; i++) begin
      if (hit(ra, lft_pkg::IDX_TRIM[i])) begin
        rd_val[7:0] = trim_q[i];
        rd_hit = 1'b1;
      end
    end
  end

  // Read channel; one read in flight, answered the cycle after the address
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= lft_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_val;
      rresp_q  <= rd_hit ? lft_pkg::RESP_OKAY : lft_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  AST_SET: assert property ((LANE_FAULT != 16'h0000) |=>
    ((flags_q & $past(LANE_FAULT)) == $past(LANE_FAULT)))
    else $error("Lane fault flag not set");
  AST_CLR: assert property ((wr_fault && lane_clr != 16'h0000 && !sum_clr) |=>
    (flags_q == (($past(flags_q) & ~$past(lane_clr)) | $past(LANE_FAULT))))
    else $error("Lane clear wrong");
  AST_PERSIST: assert property ((lane_clr[0] && LANE_FAULT[0]) ##1 LANE_FAULT[0] |=> flags_q[0])
    else $error("Persistent fault hidden");
  AST_SUMCLR: assert property (sum_clr |=> flags_q == $past(LANE_FAULT))
    else $error("Summary clear missed lanes");
  AST_RST: assert property ($past(RST) |-> flags_q == lft_pkg::FAULT_RST)
    else $error("Flags not all set after reset");
  AST_DUAL_A: assert property (MODE.dual |=> APPLIED.core_a == $past(trim_q[0]))
    else $error("Core A dual trim not applied");
  AST_DUAL_B: assert property ((MODE.dual && MODE.fg_cal) |=> APPLIED.core_b == $past(trim_q[1]))
    else $error("Core B dual trim not applied");
  AST_SGL_A: assert property ((!MODE.dual && MODE.fg_cal && !MODE.in_b) |=>
    (APPLIED.core_a == $past(trim_q[2]) && APPLIED.core_b == $past(trim_q[3])))
    else $error("Single input A trims wrong");
  AST_SGL_AB: assert property ((!MODE.dual && MODE.fg_cal && MODE.in_b) |=> APPLIED.core_a == $past(trim_q[4]))
    else $error("Core A input B trim wrong");
  AST_SGL_BB: assert property ((!MODE.dual && MODE.fg_cal && MODE.in_b) |=> APPLIED.core_b == $past(trim_q[5]))
    else $error("Core B input B trim wrong");
  AST_SUM: assert property (any_act |=> sum_q)
    else $error("Summary bit not set");
  AST_SETWIN: assert property ((lane_clr[0] && LANE_FAULT[0]) |=> flags_q[0])
    else $error("Clear beat a same-cycle fault");
  AST_BRESP: assert property ((S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && !bvalid_q)
    |-> ##[1:2] S_AXI_BVALID)
    else $error("Write response late");

  // Flags and summary stay sticky; only an explicit write may drop a bit
  AST_HOLD: assert property ((!wr_fault && !sum_clr) |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
    else $error("Lane flag dropped without a clear");
  AST_ZERO_KEEP: assert property ((wr_fault && !sum_clr) |=>
    ((flags_q & ~$past(lane_clr)) == (($past(flags_q) | $past(LANE_FAULT)) & ~$past(lane_clr))))
    else $error("Zero bit of a clear changed a flag");
  AST_SUM_CLR: assert property ((sum_clr && !any_act) |=> !sum_q)
    else $error("Summary bit not cleared");
  AST_SUM_HOLD: assert property ((sum_q && !sum_clr) |=> sum_q)
    else $error("Summary bit dropped without a clear");
  AST_IRQ_EVT: assert property (new_fault |=> irq_sts_q[lft_pkg::IRQ_LANE])
    else $error("Lane fault event not latched for interrupt");

  // Read answer timing; a stalled master must see the answer held unchanged
  AST_RD_ANS: assert property ((S_AXI_ARVALID && S_AXI_ARREADY) |=> S_AXI_RVALID)
    else $error("Read answer late");
  AST_RD_HOLD: assert property ((S_AXI_RVALID && !S_AXI_RREADY) |=> (S_AXI_RVALID && $stable(S_AXI_RDATA)))
    else $error("Read answer not held");

endmodule

// [verilog/lft_pkg.sv]
// Purpose: Shared constants and types for the lane fault and sample trim bank
// Assumes: Registers sit at four times their printed index on a 32-bit bus
// Notes:   Trim slots are ordered as in the trim index table below
package lft_pkg;
  localparam int        ADDR_W      = 12;
  localparam int        LANES       = 16;
  localparam int        TRIMS       = 6;
  localparam int        TRIM_W      = 8;
  // Register indices; byte address is the index shifted left by two
  localparam logic [9:0] IDX_ALARM   = 10'h2c1;
  localparam logic [9:0] IDX_FAULT   = 10'h2c4;
  localparam logic [9:0] IDX_IRQ_STS = 10'h380;
  localparam logic [9:0] IDX_IRQ_CLR = 10'h381;
  localparam logic [9:0] IDX_IRQ_EN  = 10'h382;
  localparam logic [9:0] IDX_TRIM [TRIMS] = '{10'h310, 10'h313, 10'h314, 10'h315, 10'h31a, 10'h31b};
  // Trim slot numbers
  localparam int        T_A_DUAL    = 0;
  localparam int        T_B_DUAL    = 1;
  localparam int        T_A_IN_A    = 2;
  localparam int        T_B_IN_A    = 3;
  localparam int        T_A_IN_B    = 4;
  localparam int        T_B_IN_B    = 5;
  // Field positions and reset values
  localparam int        SUM_BIT     = 5;
  localparam int        IRQ_LANE    = 0;
  localparam int        IRQ_W       = 1;
  localparam logic [15:0] FAULT_RST = 16'hffff;
  localparam logic      SUM_RST     = 1'b1;
  localparam logic [7:0] TRIM_RST   = 8'h00;
  localparam logic [1:0] RESP_OKAY  = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef logic [TRIM_W-1:0] lft_trim_t;

  // Converter operating mode seen by the trim selector
  typedef struct packed {
    logic dual;
    logic fg_cal;
    logic in_b;
  } lft_mode_s;

  // Trim values in force for the two cores
  typedef struct packed {
    lft_trim_t core_a;
    lft_trim_t core_b;
  } lft_pair_s;
endpackage

// [verif/lft_top_bench.sv]
// Purpose: Self-checking bench for the lane fault flags and sample trim bank
// Assumes: Register answers arrive over AXI4-Lite; the bench waits on handshakes, never on fixed latency
// Notes:   Each test is one task; ready and valid are sampled mid-cycle so the edge outcome is known
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module lft_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_FLG = {lft_pkg::IDX_FAULT, 2'b00};
  localparam logic [11:0] A_ALM = {lft_pkg::IDX_ALARM, 2'b00};
  localparam logic [11:0] A_STS = {lft_pkg::IDX_IRQ_STS, 2'b00};
  localparam logic [11:0] A_CLR = {lft_pkg::IDX_IRQ_CLR, 2'b00};
  localparam logic [11:0] A_EN  = {lft_pkg::IDX_IRQ_EN, 2'b00};
  logic               clk_sys, rst, aw_valid, w_valid, b_ready, ar_valid, r_ready, fuse_load;
  logic               aw_ready, w_ready, b_valid, ar_ready, r_valid, irq;
  logic [11:0]        aw_addr, ar_addr;
  logic [31:0]        w_data, r_data, d;
  logic [3:0]         w_strb;
  logic [1:0]         b_resp, r_resp, r;
  logic [15:0]        lane_fault, lane_active;
  logic [47:0]        fuse_trim;
  logic [7:0]         tv [6];
  lft_pkg::lft_mode_s mode;
  lft_pkg::lft_pair_s applied;
  int                 num_errors, checked;

  lft_top dut_u (.CLK_SYS(clk_sys), .RST(rst), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid),
    .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid),
    .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
    .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data),
    .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready), .LANE_FAULT(lane_fault),
    .LANE_ACTIVE(lane_active), .MODE(mode), .FUSE_LOAD(fuse_load), .FUSE_TRIM(fuse_trim),
    .APPLIED(applied), .IRQ(irq));

  // Clock at 10 MHz
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Write: hold each channel until its own handshake edge, then take the response
  task automatic wr(input logic [11:0] a, input logic [31:0] dt, output logic [1:0] rs);
    logic ah, wh, bh;
    int   n;
    aw_addr <= a; w_data <= dt; w_strb <= 4'hf; aw_valid <= 1'b1; w_valid <= 1'b1; b_ready <= 1'b1;
    bh = 1'b0;
    n = 0;
    while (!bh && n < 50) begin
      @(negedge clk_sys);
      ah = aw_valid & aw_ready;
      wh = w_valid & w_ready;
      bh = b_valid;
      rs = b_resp;
      @(posedge clk_sys);
      n++;
      if (ah) aw_valid <= 1'b0;
      if (wh) w_valid <= 1'b0;
    end
    b_ready <= 1'b0;
    if (!bh) num_errors++;
    cyc(1); // Let an edge pass so the next call never re-raises bready in the same step
  endtask

  // Read: address held until taken, rready held until rvalid is seen
  task automatic rd(input logic [11:0] a, output logic [31:0] dt, output logic [1:0] rs);
    logic ah, rh;
    int   n;
    ar_addr <= a; ar_valid <= 1'b1; r_ready <= 1'b1;
    rh = 1'b0;
    n = 0;
    while (!rh && n < 50) begin
      @(negedge clk_sys);
      ah = ar_valid & ar_ready;
      rh = r_valid;
      dt = r_data;
      rs = r_resp;
      @(posedge clk_sys);
      n++;
      if (ah) ar_valid <= 1'b0;
    end
    r_ready <= 1'b0;
    if (!rh) num_errors++;
    cyc(1); // Let an edge pass so the next call never re-raises rready in the same step
  endtask

  task automatic pulse(input logic [15:0] f);
    lane_fault <= f;
    cyc(1);
    lane_fault <= '0;
    cyc(2);
  endtask

  task automatic t_reset();
    rd(A_FLG, d, r); `CHK(d, 32'h0000ffff);
    rd(A_ALM, d, r); `CHK(d, 32'h00000020);
    for (int k = 0; k < 6; k++) begin
      rd({lft_pkg::IDX_TRIM[k], 2'b00}, d, r); `CHK(d, 32'h0);
    end
    rd(12'hffc, d, r); `CHK({r, d}, {lft_pkg::RESP_SLVERR, 32'h0});
    $display("test reset done");
  endtask

  task automatic t_summary();
    wr(A_ALM, 32'h20, r); `CHK(r, lft_pkg::RESP_OKAY);
    rd(A_FLG, d, r); `CHK(d, 32'h0);
    rd(A_ALM, d, r); `CHK(d, 32'h0);
    pulse(16'h0004);
    rd(A_ALM, d, r); `CHK(d, 32'h20);
    rd(A_FLG, d, r); `CHK(d, 32'h4);
    $display("test summary done");
  endtask

  task automatic t_clear();
    wr(A_FLG, 32'hffff, r);
    pulse(16'h0f0f);
    rd(A_FLG, d, r); `CHK(d, 32'h0f0f);
    wr(A_FLG, 32'h0003, r);
    rd(A_FLG, d, r); `CHK(d, 32'h0f0c);
    lane_fault <= 16'h0009;
    cyc(1);
    wr(A_FLG, 32'hffff, r);
    rd(A_FLG, d, r); `CHK(d, 32'h0009);
    lane_fault <= '0;
    cyc(1);
    wr(A_FLG, 32'hffff, r);
    rd(A_FLG, d, r); `CHK(d, 32'h0);
    $display("test clear done");
  endtask

  task automatic t_irq();
    wr(A_CLR, 32'h1, r);
    rd(A_STS, d, r); `CHK(d, 32'h0);
    pulse(16'h0200);
    rd(A_STS, d, r); `CHK(d, 32'h1);
    `CHK(irq, 1'b0);
    wr(A_EN, 32'h1, r);
    cyc(2);
    `CHK(irq, 1'b1);
    wr(A_CLR, 32'h1, r);
    cyc(2);
    `CHK(irq, 1'b0);
    wr(12'hffc, 32'h1, r); `CHK(r, lft_pkg::RESP_SLVERR);
    $display("test irq done");
  endtask

  task automatic mchk(input logic [2:0] m, input logic [15:0] e);
    mode <= m;
    cyc(3);
    `CHK(applied, e);
  endtask

  task automatic t_trim();
    for (int k = 0; k < 6; k++) begin
      tv[k] = 8'(17 * (k + 1));
      wr({lft_pkg::IDX_TRIM[k], 2'b00}, {20'h0, 4'ha, tv[k]}, r);
    end
    for (int k = 0; k < 6; k++) begin
      rd({lft_pkg::IDX_TRIM[k], 2'b00}, d, r); `CHK(d, {24'h0, tv[k]});
    end
    mchk(3'b110, {tv[0], tv[1]});
    mchk(3'b100, {tv[0], tv[1]});
    mchk(3'b010, {tv[2], tv[3]});
    mchk(3'b011, {tv[4], tv[5]});
    fuse_trim <= 48'hc5c4c3c2c1c0;
    fuse_load <= 1'b1;
    cyc(1);
    fuse_load <= 1'b0;
    cyc(1);
    for (int k = 0; k < 6; k++) begin
      rd({lft_pkg::IDX_TRIM[k], 2'b00}, d, r); `CHK(d, 32'hc0 + k);
    end
    mchk(3'b011, 16'hc4c5);
    wr({lft_pkg::IDX_TRIM[0], 2'b00}, 32'h5a, r);
    rd({lft_pkg::IDX_TRIM[0], 2'b00}, d, r); `CHK(d, 32'h5a);
    $display("test trim done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Main sequence; all inputs set at time zero, reset held for ten cycles
  initial begin
    rst = 1'b1; aw_valid = 1'b0; w_valid = 1'b0; b_ready = 1'b0; ar_valid = 1'b0; r_ready = 1'b0;
    aw_addr = '0; ar_addr = '0; w_data = '0; w_strb = '0; lane_fault = '0; lane_active = 16'hffff;
    mode = 3'b110; fuse_load = 1'b0; fuse_trim = '0; num_errors = 0; checked = 0;
    cyc(10);
    rst <= 1'b0;
    cyc(1);
    t_reset();
    t_summary();
    t_clear();
    t_irq();
    t_trim();
    print_verdict();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    cyc(20000);
    num_errors++;
    print_verdict();
  end
endmodule
